// ### cow_clock_out_wait.sv
// Divided clock output and oscillator stabilisation wait, AHB-Lite slave
//
// What this block does
// - The output clock is the selected source divided by 2 to the divider code, 1/1 up to 1/128.
// - Source code 0 picks fast oscillator B, 1 the slow oscillator, 2 fast oscillator A, 3 is reserved.
// - With the output enable set the divided clock drives its pin, and clearing it stops the pin toggling.
// - After reset the output is disabled and divider and source codes are zero.
// - Fast oscillator B wait codes 0 to 3 give 64, 32, 16 or 8 of its cycles.
// - Fast oscillator A wait codes 0 to 3 give 1024, 512, 256 or 128 of its cycles.
// - Slow source B wait codes 0 to 3 give 64, 32, 16 or 8 slow cycles.
// - Slow source A wait codes 0 to 3 give 16384, 8192, 4096 or 2048 slow cycles.
// - A started oscillator is withheld from the system until its wait has been counted.
// - After reset fast oscillator B waits 64 cycles and the processor runs only after that wait.
// - Switching the system to fast oscillator B right after enabling it gets the clock only after the wait.
// - The fast oscillator B enable resets to 1 so it runs from reset.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module cow_clock_out_wait
  import cow_pkg::*;
#(
  parameter int FAST_B_WAIT_BASE = 64,
  parameter int FAST_A_WAIT_BASE = 1024,
  parameter int SLOW_B_WAIT_BASE = 64,
  parameter int SLOW_A_WAIT_BASE = 16384
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Oscillator clock pins
  input  wire logic        fast_osc_b_clk,
  input  wire logic        slow_osc_clk,
  input  wire logic        fast_osc_a_clk,
  // Oscillator enables and gate states
  output logic             fast_osc_b_on,
  output logic             slow_osc_on,
  output logic             fast_osc_a_on,
  output logic             slow_src_b_sel,
  output logic             fast_osc_b_supply,
  output logic             slow_osc_supply,
  output logic             fast_osc_a_supply,
  output logic             cpu_run,
  // Divided clock pin
  output logic             divided_clock_out_b,
  output logic             divided_clock_out_b_oe
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  localparam int CNT_MAX = (1 << WAIT_CNT_W) - 1;
  if (FAST_B_WAIT_BASE < 8 || FAST_B_WAIT_BASE > CNT_MAX ||
      FAST_A_WAIT_BASE < 8 || FAST_A_WAIT_BASE > CNT_MAX ||
      SLOW_B_WAIT_BASE < 8 || SLOW_B_WAIT_BASE > CNT_MAX ||
      SLOW_A_WAIT_BASE < 8 || SLOW_A_WAIT_BASE > CNT_MAX) begin : g_bad
    $error("cow_clock_out_wait: wait base out of range");
  end

  // Wait length halves with each step of the two-bit code
  function automatic logic [WAIT_CNT_W-1:0] wait_len(input int base,
                                                     input logic [1:0] code);
    return WAIT_CNT_W'(base >> code);
  endfunction : wait_len

  // ****************************************************************
  // State
  // ****************************************************************
  // Oscillator index: 0 fast B, 1 slow, 2 fast A (same as source code)
  typedef struct packed {
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic [2:0]  sync3;
    logic [2:0]  div;
    logic [1:0]  src;
    logic        oe;
    logic [7:0]  wait_sel;
    logic [2:0]  osc_en;
    logic        slow_sel_b;
    logic        cpu_run;
    logic        dp_write;
    cow_sel_type dp_sel;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } cow_state_type;

  localparam cow_state_type STATE_RESET = '{
    sync1: 3'h0, sync2: 3'h0, sync3: 3'h0,
    div: DIV_RESET, src: SRC_RESET, oe: 1'b0,
    wait_sel: WAIT_RESET, osc_en: OSC_EN_RESET,
    slow_sel_b: 1'b0, cpu_run: 1'b0,
    dp_write: 1'b0, dp_sel: SEL_NONE,
    hrdata: 32'h0000_0000, hreadyout: 1'b1, hresp: 1'b0
  };

  cow_state_type st_reg;
  cow_state_type st_next;

  logic [2:0] sup;
  logic [2:0] tick;
  logic       ap;
  logic       src_ok;
  logic       sel_level;
  logic       sel_tick;
  logic       sel_live;
  logic [WAIT_CNT_W-1:0] len_fb;
  logic [WAIT_CNT_W-1:0] len_fa;
  logic [WAIT_CNT_W-1:0] len_sl;

  assign ap = hsel && htrans[1] && hready;
  // Edge detect reads only the second and third stages
  assign tick = st_reg.sync2 & ~st_reg.sync3;

  // ****************************************************************
  // Wait lengths
  // ****************************************************************
  assign len_fb = wait_len(FAST_B_WAIT_BASE,
                           st_reg.wait_sel[WT_FB_LSB +: 2]);
  assign len_fa = wait_len(FAST_A_WAIT_BASE,
                           st_reg.wait_sel[WT_FA_LSB +: 2]);
  // Slow source choice picks which table governs the slow wait
  assign len_sl = st_reg.slow_sel_b ?
                  wait_len(SLOW_B_WAIT_BASE,
                           st_reg.wait_sel[WT_SB_LSB +: 2]) :
                  wait_len(SLOW_A_WAIT_BASE,
                           st_reg.wait_sel[WT_SA_LSB +: 2]);

  // ****************************************************************
  // Source multiplexer
  // ****************************************************************
  // Only a stabilised oscillator feeds the pin; reserved code stays low
  assign src_ok    = (st_reg.src != SRC_RESERVED);
  assign sel_level = src_ok && st_reg.sync2[st_reg.src];
  assign sel_tick  = src_ok && tick[st_reg.src];
  assign sel_live  = src_ok && sup[st_reg.src];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.sync1 = {fast_osc_a_clk, slow_osc_clk, fast_osc_b_clk};
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    // Processor start waits for the fast B gate, held until reset
    st_next.cpu_run = st_reg.cpu_run | sup[0];

    if (st_reg.dp_write) begin
      unique case (st_reg.dp_sel)
        SEL_OUT: begin
          // Bits 7 and 1 have no storage
          st_next.div = hwdata[DIV_LSB +: 3];
          st_next.src = hwdata[SRC_LSB +: 2];
          st_next.oe  = hwdata[OE_BIT];
        end
        SEL_WAIT: begin
          st_next.wait_sel = hwdata[7:0];
        end
        SEL_OSC: begin
          st_next.slow_sel_b = hwdata[OSC_SSEL_BIT];
          st_next.osc_en     = {hwdata[OSC_FA_BIT], hwdata[OSC_SL_BIT],
                                hwdata[OSC_FB_BIT]};
        end
        SEL_STAT: begin
        end
        SEL_NONE: begin
        end
      endcase
    end

    st_next.dp_write = ap && hwrite && (hsize == HSIZE_WORD);
    st_next.dp_sel   = ap ? cow_decode(haddr) : SEL_NONE;

    // Read data built from the updated registers so a write followed
    // directly by a read returns the new value
    if (ap && !hwrite) begin
      unique case (cow_decode(haddr))
        SEL_OUT: begin
          st_next.hrdata = {24'h000000, 1'b0, st_next.div,
                            st_next.src, 1'b0, st_next.oe};
        end
        SEL_WAIT: begin
          st_next.hrdata = {24'h000000, st_next.wait_sel};
        end
        SEL_OSC: begin
          st_next.hrdata = {28'h0000000, st_next.slow_sel_b,
                            st_next.osc_en[0], st_next.osc_en[1],
                            st_next.osc_en[2]};
        end
        SEL_STAT: begin
          st_next.hrdata = {28'h0000000, st_reg.cpu_run,
                            sup[0], sup[1], sup[2]};
        end
        SEL_NONE: begin
          st_next.hrdata = 32'h0000_0000;
        end
      endcase
    end
    st_next.hreadyout = 1'b1;
    st_next.hresp     = 1'b0;
  end

  // Reset: output off, codes zero, only fast oscillator B enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Wait counters and divider
  // ****************************************************************
  cow_wait_counter #(.CNT_W(WAIT_CNT_W)) u_wait_fb (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .osc_on   (st_reg.osc_en[0]),
    .osc_tick (tick[0]),
    .wait_len (len_fb),
    .supply   (sup[0])
  );

  cow_wait_counter #(.CNT_W(WAIT_CNT_W)) u_wait_sl (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .osc_on   (st_reg.osc_en[1]),
    .osc_tick (tick[1]),
    .wait_len (len_sl),
    .supply   (sup[1])
  );

  cow_wait_counter #(.CNT_W(WAIT_CNT_W)) u_wait_fa (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .osc_on   (st_reg.osc_en[2]),
    .osc_tick (tick[2]),
    .wait_len (len_fa),
    .supply   (sup[2])
  );

  cow_divider #(.CNT_W(DIV_CNT_W)) u_div (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .enable   (st_reg.oe),
    .live     (sel_live),
    .div_code (st_reg.div),
    .level    (sel_level),
    .tick     (sel_tick),
    .clk_out  (divided_clock_out_b)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hrdata                 = st_reg.hrdata;
  assign hreadyout              = st_reg.hreadyout;
  assign hresp                  = st_reg.hresp;
  assign fast_osc_b_on          = st_reg.osc_en[0];
  assign slow_osc_on            = st_reg.osc_en[1];
  assign fast_osc_a_on          = st_reg.osc_en[2];
  assign slow_src_b_sel         = st_reg.slow_sel_b;
  assign fast_osc_b_supply      = sup[0];
  assign slow_osc_supply        = sup[1];
  assign fast_osc_a_supply      = sup[2];
  assign cpu_run                = st_reg.cpu_run;
  assign divided_clock_out_b_oe = st_reg.oe;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_out_off;
    !st_reg.oe ##1 !st_reg.oe;
  endsequence

  sequence s_undivided_b;
    (st_reg.oe && st_reg.div == 3'h0 && st_reg.src == 2'h0 && sup[0])
    ##1
    (st_reg.oe && st_reg.div == 3'h0 && st_reg.src == 2'h0 && sup[0]);
  endsequence

  chk_out_stops_low: assert property (
    s_out_off |-> !divided_clock_out_b)
    else $error("divided clock toggles while output disabled");

  chk_undivided_follow: assert property (
    s_undivided_b |-> divided_clock_out_b == $past(st_reg.sync2[0]))
    else $error("undivided output does not follow fast osc B");

  chk_reserved_src: assert property (
    (st_reg.src == SRC_RESERVED) ##1 (st_reg.src == SRC_RESERVED)
    |-> !divided_clock_out_b)
    else $error("reserved source drives the output");

  chk_fb_wait_min: assert property (
    $rose(st_reg.osc_en[0]) |-> !sup[0] [*8])
    else $error("fast osc B supplied before shortest wait");

  chk_cpu_after_wait: assert property (
    $rose(st_reg.cpu_run) |-> $past(sup[0]))
    else $error("processor started without fast osc B supply");

  chk_fa_gate_close: assert property (
    $fell(st_reg.osc_en[2]) |=> !sup[2])
    else $error("fast osc A gate stays open after disable");

  chk_slow_gate_on: assert property (
    sup[1] |-> $past(st_reg.osc_en[1]))
    else $error("slow oscillator supplied while disabled");

  chk_reserved_read: assert property (
    (ap && !hwrite && cow_decode(haddr) == SEL_OUT)
    |=> (hrdata[7] == 1'b0 && hrdata[1] == 1'b0 &&
         hrdata[31:8] == 24'h000000))
    else $error("reserved output control bits read non-zero");

endmodule : cow_clock_out_wait
`default_nettype wire

// ### cow_divider.sv
// Power-of-two divider for the second divided clock output
`timescale 1ns/1ps
`default_nettype none
module cow_divider
  import cow_pkg::*;
#(
  parameter int CNT_W = DIV_CNT_W
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Control
  input  wire logic       enable,
  input  wire logic       live,
  input  wire logic [2:0] div_code,
  // Selected source
  input  wire logic       level,
  input  wire logic       tick,
  // Divided output
  output logic            clk_out
);

  if (CNT_W < DIV_CNT_W) begin : g_bad_width
    $error("cow_divider: CNT_W cannot reach 1/128");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             out;
  } cow_div_state_type;

  cow_div_state_type st_reg;
  cow_div_state_type st_next;

  always_comb begin
    st_next = st_reg;
    if (!enable || !live) begin
      // Output parks low so the pin stops toggling
      st_next.cnt = '0;
      st_next.out = 1'b0;
    end else begin
      if (tick) begin
        st_next.cnt = st_reg.cnt + 1'b1;
      end
      // Counter bit k has a period of 2^(k+1) source cycles
      if (div_code == 3'h0) begin
        st_next.out = level;
      end else begin
        st_next.out = st_reg.cnt[div_code - 3'h1];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign clk_out = st_reg.out;

endmodule : cow_divider
`default_nettype wire

// ### cow_far_side.sv
// Oscillator sources and divided clock pin receiver for the block
`timescale 1ns/1ps
`default_nettype none
module cow_far_side #(
  parameter int FB_HALF = 24,
  parameter int SL_HALF = 40,
  parameter int FA_HALF = 32
) (
  // Oscillator enables from the block
  input  wire logic fast_osc_b_on,
  input  wire logic slow_osc_on,
  input  wire logic fast_osc_a_on,
  // Oscillator clocks to the block
  output var logic  fast_osc_b_clk,
  output var logic  slow_osc_clk,
  output var logic  fast_osc_a_clk,
  // Divided clock pin
  input  wire logic divided_clock_out_b,
  input  wire logic divided_clock_out_b_oe,
  // Pin measurements
  output var int    period_ns,
  output var int    rise_count
);
  // ****************************************************************
  // Oscillators
  // ****************************************************************
  // A stopped oscillator sits low. Half periods are multiples of 8 ns,
  // so no oscillator edge lands on a rising hclk edge.
  initial fast_osc_b_clk = 1'b0;
  initial slow_osc_clk = 1'b0;
  initial fast_osc_a_clk = 1'b0;
  always #(FB_HALF) fast_osc_b_clk = fast_osc_b_on ? ~fast_osc_b_clk : 1'b0;
  always #(SL_HALF) slow_osc_clk = slow_osc_on ? ~slow_osc_clk : 1'b0;
  always #(FA_HALF) fast_osc_a_clk = fast_osc_a_on ? ~fast_osc_a_clk : 1'b0;

  // ****************************************************************
  // Pin receiver
  // ****************************************************************
  // The pin has a pull-down, so a released pin reads low
  wire logic pin_level;
  longint    last_rise;
  assign pin_level = divided_clock_out_b_oe ? divided_clock_out_b : 1'b0;
  initial period_ns = 0;
  initial rise_count = 0;
  initial last_rise = 0;
  always @(posedge pin_level) begin
    period_ns = int'($time - last_rise);
    last_rise = $time;
    rise_count = rise_count + 1;
  end
endmodule : cow_far_side
`default_nettype wire

// ### cow_pkg.sv
// Constants and types shared by the clock output and oscillator wait block
package cow_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [29:0] OUT_CTL_IDX  = 30'h0000_5065;
  localparam logic [29:0] WAIT_CTL_IDX = 30'h0000_507D;
  localparam logic [29:0] OSC_CTL_IDX  = 30'h0000_5090;
  localparam logic [29:0] STAT_IDX     = 30'h0000_5091;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DIV_LSB      = 4;
  localparam int SRC_LSB      = 2;
  localparam int OE_BIT       = 0;
  localparam int WT_FB_LSB    = 6;
  localparam int WT_FA_LSB    = 4;
  localparam int WT_SB_LSB    = 2;
  localparam int WT_SA_LSB    = 0;
  localparam int OSC_SSEL_BIT = 3;
  localparam int OSC_FB_BIT   = 2;
  localparam int OSC_SL_BIT   = 1;
  localparam int OSC_FA_BIT   = 0;

  // ****************************************************************
  // Reset values and encodings
  // ****************************************************************
  localparam logic [2:0] DIV_RESET  = 3'h0;
  localparam logic [1:0] SRC_RESET  = 2'h0;
  localparam logic [7:0] WAIT_RESET = 8'h00;
  localparam logic [2:0] OSC_EN_RESET = 3'h1;
  localparam logic [1:0] SRC_RESERVED = 2'h3;
  localparam logic [2:0] HSIZE_WORD   = 3'h2;
  localparam int WAIT_CNT_W = 15;
  localparam int DIV_CNT_W  = 7;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_OUT  = 3'b001,
    SEL_WAIT = 3'b010,
    SEL_OSC  = 3'b011,
    SEL_STAT = 3'b100
  } cow_sel_type;

  function automatic cow_sel_type cow_decode(input logic [31:0] addr);
    cow_sel_type sel;
    sel = SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      if (addr[31:2] == OUT_CTL_IDX) sel = SEL_OUT;
      else if (addr[31:2] == WAIT_CTL_IDX) sel = SEL_WAIT;
      else if (addr[31:2] == OSC_CTL_IDX) sel = SEL_OSC;
      else if (addr[31:2] == STAT_IDX) sel = SEL_STAT;
    end
    return sel;
  endfunction : cow_decode

endpackage : cow_pkg

// ### cow_wait_counter.sv
// Stabilisation wait counter and clock gate for one oscillator
`timescale 1ns/1ps
`default_nettype none
module cow_wait_counter
  import cow_pkg::*;
#(
  parameter int CNT_W = WAIT_CNT_W
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Oscillator side
  input  wire logic             osc_on,
  input  wire logic             osc_tick,
  input  wire logic [CNT_W-1:0] wait_len,
  // Gate state
  output logic                  supply
);

  if (CNT_W < 4) begin : g_bad_width
    $error("cow_wait_counter: CNT_W too small");
  end

  typedef struct packed {
    logic             on_prev;
    logic [CNT_W-1:0] count;
    logic             supply;
  } cow_wait_state_type;

  cow_wait_state_type st_reg;
  cow_wait_state_type st_next;

  always_comb begin
    st_next = st_reg;
    st_next.on_prev = osc_on;
    if (!osc_on || !st_reg.on_prev) begin
      // Restart on every off-to-on edge; gate closes while off
      st_next.count  = '0;
      st_next.supply = 1'b0;
    end else if (!st_reg.supply && osc_tick) begin
      st_next.count = st_reg.count + 1'b1;
      if (st_next.count >= wait_len) begin
        st_next.supply = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign supply = st_reg.supply;

endmodule : cow_wait_counter
`default_nettype wire

// ### testbench.sv
// Self-checking testbench for the clock output and oscillator wait block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cow_pkg::*;
  // Wait bases kept small so every code runs quickly
  localparam logic [15:0] FB_W = 16'h0040;
  localparam logic [15:0] FA_W = 16'h0100;
  localparam logic [15:0] SB_W = 16'h0040;
  localparam logic [15:0] SA_W = 16'h0080;
  typedef struct packed {
    logic [1:0]  sel;
    logic        slb;
    logic [1:0]  wc;
    logic [2:0]  div;
    logic [15:0] n;
  } cow_row_type;
  // Source/oscillator, slow source B, wait code, divider, wait cycles
  localparam cow_row_type ROWS [16] = '{
    '{2'h0, 1'b0, 2'h0, 3'h0, FB_W}, '{2'h0, 1'b0, 2'h1, 3'h1, FB_W >> 1},
    '{2'h0, 1'b0, 2'h2, 3'h2, FB_W >> 2}, '{2'h0, 1'b0, 2'h3, 3'h3, FB_W >> 3},
    '{2'h2, 1'b0, 2'h0, 3'h4, FA_W}, '{2'h2, 1'b0, 2'h1, 3'h5, FA_W >> 1},
    '{2'h2, 1'b0, 2'h2, 3'h6, FA_W >> 2}, '{2'h2, 1'b0, 2'h3, 3'h7, FA_W >> 3},
    '{2'h1, 1'b1, 2'h0, 3'h0, SB_W}, '{2'h1, 1'b1, 2'h1, 3'h1, SB_W >> 1},
    '{2'h1, 1'b1, 2'h2, 3'h2, SB_W >> 2}, '{2'h1, 1'b1, 2'h3, 3'h3, SB_W >> 3},
    '{2'h1, 1'b0, 2'h0, 3'h4, SA_W}, '{2'h1, 1'b0, 2'h1, 3'h5, SA_W >> 1},
    '{2'h1, 1'b0, 2'h2, 3'h6, SA_W >> 2}, '{2'h1, 1'b0, 2'h3, 3'h7, SA_W >> 3}};

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        fast_osc_b_clk;
  logic        slow_osc_clk;
  logic        fast_osc_a_clk;
  logic        fast_osc_b_on;
  logic        slow_osc_on;
  logic        fast_osc_a_on;
  logic        slow_src_b_sel;
  logic        fast_osc_b_supply;
  logic        slow_osc_supply;
  logic        fast_osc_a_supply;
  logic        cpu_run;
  logic        divided_clock_out_b;
  logic        divided_clock_out_b_oe;
  int          period_ns;
  int          rise_count;
  int          bad_count;
  int          n_tests;
  int          r, k, p, lsb, hi;
  longint      t0;
  logic [31:0] d;
  logic [2:0]  en;
  cow_row_type row;

  cow_clock_out_wait #(
    .FAST_B_WAIT_BASE(FB_W),
    .FAST_A_WAIT_BASE(FA_W),
    .SLOW_B_WAIT_BASE(SB_W),
    .SLOW_A_WAIT_BASE(SA_W)
  ) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .fast_osc_b_clk(fast_osc_b_clk),
    .slow_osc_clk(slow_osc_clk), .fast_osc_a_clk(fast_osc_a_clk),
    .fast_osc_b_on(fast_osc_b_on), .slow_osc_on(slow_osc_on),
    .fast_osc_a_on(fast_osc_a_on), .slow_src_b_sel(slow_src_b_sel),
    .fast_osc_b_supply(fast_osc_b_supply),
    .slow_osc_supply(slow_osc_supply),
    .fast_osc_a_supply(fast_osc_a_supply), .cpu_run(cpu_run),
    .divided_clock_out_b(divided_clock_out_b),
    .divided_clock_out_b_oe(divided_clock_out_b_oe)
  );

  cow_far_side far (
    .fast_osc_b_on(fast_osc_b_on), .slow_osc_on(slow_osc_on),
    .fast_osc_a_on(fast_osc_a_on), .fast_osc_b_clk(fast_osc_b_clk),
    .slow_osc_clk(slow_osc_clk), .fast_osc_a_clk(fast_osc_a_clk),
    .divided_clock_out_b(divided_clock_out_b),
    .divided_clock_out_b_oe(divided_clock_out_b_oe),
    .period_ns(period_ns), .rise_count(rise_count)
  );

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic print_verdict;
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_rng(input int got, input int lo, input int hi_lim);
    n_tests++;
    if (got < lo || got > hi_lim) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi_lim);
    end
  endtask : check_rng

  // Every wait is bounded; running out ends the run as a failure
  task automatic wait_rdy;
    int i;
    for (i = 0; i < 100 && hreadyout !== 1'b1; i++) @(posedge hclk);
    if (i == 100) begin
      bad_count++;
      print_verdict();
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [29:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    @(posedge hclk);
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [29:0] idx, input logic [31:0] wd);
    logic [31:0] unused;
    bus(1'b1, idx, wd, unused);
  endtask : wr

  function automatic logic probe(input int sel);
    case (sel)
      0: return fast_osc_b_supply;
      1: return slow_osc_supply;
      2: return fast_osc_a_supply;
      default: return cpu_run;
    endcase
  endfunction : probe

  task automatic wait_hi(input int sel, input int lim);
    int i;
    for (i = 0; i < lim && probe(sel) !== 1'b1; i++) @(negedge hclk);
    if (i == lim) begin
      bad_count++;
      print_verdict();
    end
  endtask : wait_hi

  task automatic wait_rises(input int cnt, input int lim);
    int i;
    int c0;
    c0 = rise_count;
    for (i = 0; i < lim && rise_count < c0 + cnt; i++) @(negedge hclk);
    if (i == lim) begin
      bad_count++;
      print_verdict();
    end
  endtask : wait_rises

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    bad_count = 0;
    n_tests = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (r = 0; r < 16; r++) begin
      row = ROWS[r];
      k = int'(row.sel);
      p = row.sel == 2'h0 ? 48 : row.sel == 2'h1 ? 80 : 64;
      wr(OSC_CTL_IDX, {28'h0, row.slb, 3'h0});
      repeat (2) @(negedge hclk);
      check_val({31'h0, probe(k)}, 32'h0);
      lsb = row.sel == 2'h0 ? WT_FB_LSB : row.sel == 2'h2 ? WT_FA_LSB :
            row.slb ? WT_SB_LSB : WT_SA_LSB;
      wr(WAIT_CTL_IDX, {30'h0, row.wc} << lsb);
      en = row.sel == 2'h0 ? 3'h4 : row.sel == 2'h1 ? 3'h2 : 3'h1;
      wr(OSC_CTL_IDX, {28'h0, row.slb, en});
      t0 = $time;
      wait_hi(k, 30000);
      check_rng(int'($time - t0), (int'(row.n) - 1) * p, int'(row.n) * p + 64);
      d = {28'h0, slow_src_b_sel, fast_osc_b_on, slow_osc_on, fast_osc_a_on};
      check_val(d, {28'h0, row.slb, en});
      wr(OUT_CTL_IDX, {25'h0, row.div, row.sel, 2'h1});
      wait_rises(3, 20000);
      check_rng(period_ns, (p << row.div) - 8, (p << row.div) + 8);
    end
    // Reserved source keeps the pin low; reserved bits read zero
    wr(OUT_CTL_IDX, 32'h0000_00FF);
    bus(1'b0, OUT_CTL_IDX, 32'h0, d);
    check_val(d, 32'h0000_007D);
    hi = 0;
    repeat (300) @(negedge hclk) if (divided_clock_out_b !== 1'b0) hi++;
    check_val(32'(hi), 32'h0);
    wr(OUT_CTL_IDX, 32'h0000_0005);
    wait_rises(2, 2000);
    wr(OUT_CTL_IDX, 32'h0000_0004);
    // Enable register updates in the write's last edge; look once settled
    @(negedge hclk);
    check_val({31'h0, divided_clock_out_b_oe}, 32'h0);
    hi = 0;
    repeat (300) @(negedge hclk) if (divided_clock_out_b !== 1'b0) hi++;
    check_val(32'(hi), 32'h0);
    bus(1'b0, 30'h0000_5066, 32'h0, d);
    check_val(d, 32'h0);
    // Second reset in mid-run
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    check_val({27'h0, hresp, fast_osc_b_on, cpu_run, divided_clock_out_b_oe,
               fast_osc_b_supply}, 32'h0000_0008);
    hresetn <= 1'b1;
    t0 = $time;
    bus(1'b0, OUT_CTL_IDX, 32'h0, d);
    check_val(d, 32'h0);
    bus(1'b0, WAIT_CTL_IDX, 32'h0, d);
    check_val(d, 32'h0);
    bus(1'b0, OSC_CTL_IDX, 32'h0, d);
    check_val(d, 32'h0000_0004);
    wait_hi(3, 5000);
    check_rng(int'($time - t0), 63 * 48, 64 * 48 + 64);
    bus(1'b0, STAT_IDX, 32'h0, d);
    check_val(d, 32'h0000_000C);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
